// File: hw/bcd_rtc_timekeeping_core.v
`timescale 1ns/100ps
`include "rtc_core_defines.vh"
// Overview of operation
// - Locations 0 to 15 are read at addresses 00h-0Fh and written at addresses 80h-8Fh.
// - The pointer advances after every data byte and wraps from 0Fh to 00h.
// - When an access begins the running time is copied to a snapshot that reads of locations 0 to 7 are served from.
// - The 4096 Hz input is divided by 41 for 24 periods and by 40 for one to give 100 Hz.
// - All time and calendar registers hold and count in BCD, one digit per nibble.
// - Day of week advances at midnight from 1 to 7 and wraps back to 1.
// - Hours bit 6 set selects 12-hour counting, clear selects 24-hour counting.
// - In 12-hour mode hours bit 5 is the PM flag and hours run 1 to 12.
// - In 24-hour mode hours bit 5 is the second tens bit and hours run 00 to 23.
// - The century bit in month bit 7 toggles when the year rolls from 99 to 00.
// - The date returns to 01 after the last day of the month, including leap years.
// - Many bytes may pass in one select period with the pointer advancing between them.
module bcd_rtc_timekeeping_core (
  // Clock and reset
  input  wire core_clk,
  input  wire resetn,
  // Timebase tap, 4096 Hz from the oscillator chain
  input  wire tap4096,
  // Serial port pins
  input  wire threeWireMode,
  input  wire selPin,
  input  wire sclk,
  input  wire sdi,
  output reg  sdo,
  output reg  sdoOe
);

  // Synchronised pin levels, one flop of history for edge finding.
  wire [4:0] pinSync;
  wire       tapS;
  wire       sclkS;
  wire       selS;
  wire       sdiS;
  wire       wire3S;
  reg        tapPrev_r;
  reg        sclkPrev_r;
  reg        selPrev_r;
  wire       tapRise;
  wire       sclkRise;
  wire       sclkFall;
  wire       selActive;
  wire       selActivePrev;
  wire       accessStart;
  wire       tick100;

  sync_two_flop #(
    .WIDTH(5)
  ) u_sync (
    .core_clk(core_clk),
    .resetn  (resetn),
    .asyncIn ({threeWireMode, sdi, selPin, sclk, tap4096}),
    .syncOut (pinSync)
  );

  assign tapS   = pinSync[0];
  assign sclkS  = pinSync[1];
  assign selS   = pinSync[2];
  assign sdiS   = pinSync[3];
  assign wire3S = pinSync[4];

  assign tapRise   = tapS & ~tapPrev_r;
  assign sclkRise  = sclkS & ~sclkPrev_r;
  assign sclkFall  = ~sclkS & sclkPrev_r;
  // The 4-wire port selects on a low pin, the 3-wire port on a high one.
  assign selActive     = wire3S ? selS : ~selS;
  assign selActivePrev = wire3S ? selPrev_r : ~selPrev_r;
  assign accessStart   = selActive & ~selActivePrev;

  hundredths_divider u_div (
    .core_clk(core_clk),
    .resetn  (resetn),
    .inPulse (tapRise),
    .tickOut (tick100)
  );

  // Register storage and the snapshot used by reads.
  reg [7:0] regFile_r [0:15];
  reg [7:0] snap_r    [0:`NUM_TIME_REGS-1];

  function [7:0] bcdInc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcdInc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcdInc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  function [7:0] readMask;
    input [3:0] idx;
    begin
      case (idx)
        `IDX_HUND:    readMask = `MASK_HUND;
        `IDX_SEC:     readMask = `MASK_SEC;
        `IDX_MIN:     readMask = `MASK_MIN;
        `IDX_HOUR:    readMask = `MASK_HOUR;
        `IDX_DOW:     readMask = `MASK_DOW;
        `IDX_DATE:    readMask = `MASK_DATE;
        `IDX_MONTH:   readMask = `MASK_MONTH;
        `IDX_YEAR:    readMask = `MASK_YEAR;
        `IDX_CONTROL: readMask = `MASK_CONTROL;
        `IDX_STATUS:  readMask = `MASK_STATUS;
        default:      readMask = `MASK_FULL;
      endcase
    end
  endfunction

  // Leap test on the two-digit BCD year: divisible by four.
  function isLeap;
    input [7:0] y;
    begin
      if (y[4]) begin
        isLeap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end else begin
        isLeap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
    end
  endfunction

  function [7:0] lastDay;
    input [4:0] m;
    input [7:0] y;
    begin
      case (m)
        5'h02:   lastDay = isLeap(y) ? 8'h29 : 8'h28;
        5'h04:   lastDay = 8'h30;
        5'h06:   lastDay = 8'h30;
        5'h09:   lastDay = 8'h30;
        5'h11:   lastDay = 8'h30;
        default: lastDay = 8'h31;
      endcase
    end
  endfunction

  // Counter chain, all in BCD.
  wire [7:0] hundCur;
  wire [7:0] secCur;
  wire [7:0] minCur;
  wire [7:0] hourCur;
  wire [7:0] dowCur;
  wire [7:0] dateCur;
  wire [7:0] monCur;
  wire [7:0] yearCur;
  wire       mode12;
  wire       pmCur;
  wire [7:0] dimCur;
  wire       carHund;
  wire       carSec;
  wire       carMin;
  wire       carHour;
  wire       carDate;
  wire       carMon;
  wire       carYear;
  reg  [7:0] hundNxt;
  reg  [7:0] secNxt;
  reg  [7:0] minNxt;
  reg  [7:0] hourNxt;
  reg  [7:0] dowNxt;
  reg  [7:0] dateNxt;
  reg  [7:0] monNxt;
  reg  [7:0] yearNxt;

  assign hundCur = regFile_r[`IDX_HUND];
  assign secCur  = regFile_r[`IDX_SEC];
  assign minCur  = regFile_r[`IDX_MIN];
  assign hourCur = regFile_r[`IDX_HOUR];
  assign dowCur  = regFile_r[`IDX_DOW];
  assign dateCur = regFile_r[`IDX_DATE];
  assign monCur  = regFile_r[`IDX_MONTH];
  assign yearCur = regFile_r[`IDX_YEAR];
  assign mode12  = hourCur[`HOUR_MODE12_BIT];
  assign pmCur   = hourCur[`HOUR_PM_BIT];
  assign dimCur  = lastDay(monCur[4:0], yearCur);

  assign carHund = tick100 & (hundCur == 8'h99);
  assign carSec  = carHund & (secCur[6:0] == 7'h59);
  assign carMin  = carSec & (minCur[6:0] == 7'h59);
  // Midnight is 11 PM to 12 AM in 12-hour mode and 23 to 00 otherwise.
  assign carHour = carMin & (mode12 ? (pmCur && hourCur[4:0] == 5'h11)
                                    : (hourCur[5:0] == 6'h23));
  assign carDate = carHour & (dateCur[5:0] == dimCur[5:0]);
  assign carMon  = carDate & (monCur[4:0] == 5'h12);
  assign carYear = carMon & (yearCur == 8'h99);

  always @* begin
    hundNxt = hundCur;
    secNxt  = secCur;
    minNxt  = minCur;
    hourNxt = hourCur;
    dowNxt  = dowCur;
    dateNxt = dateCur;
    monNxt  = monCur;
    yearNxt = yearCur;
    if (tick100) begin
      hundNxt = carHund ? 8'h00 : bcdInc(hundCur);
    end
    if (carHund) begin
      secNxt = carSec ? 8'h00 : bcdInc(secCur);
    end
    if (carSec) begin
      minNxt = carMin ? 8'h00 : bcdInc(minCur);
    end
    if (carMin) begin
      if (mode12) begin
        if (hourCur[4:0] == 5'h12) begin
          hourNxt = {2'b01, pmCur, 5'h01};
        end else if (hourCur[4:0] == 5'h11) begin
          hourNxt = {2'b01, ~pmCur, 5'h12};
        end else begin
          hourNxt      = bcdInc({3'b000, hourCur[4:0]});
          hourNxt[7:5] = {2'b01, pmCur};
        end
      end else begin
        hourNxt = (hourCur[5:0] == 6'h23) ? 8'h00 : bcdInc({2'b00, hourCur[5:0]});
      end
    end
    if (carHour) begin
      dowNxt  = (dowCur[2:0] == 3'h7) ? 8'h01 : bcdInc(dowCur);
      dateNxt = carDate ? 8'h01 : bcdInc(dateCur);
    end
    if (carDate) begin
      monNxt = {monCur[`MONTH_CENT_BIT], 7'h00} | (carMon ? 8'h01 : bcdInc({3'b000, monCur[4:0]}));
    end
    if (carMon) begin
      yearNxt = carYear ? 8'h00 : bcdInc(yearCur);
    end
    if (carYear) begin
      monNxt[`MONTH_CENT_BIT] = ~monCur[`MONTH_CENT_BIT];
    end
  end

  // Serial engine, clocked from edges of the synchronised serial clock.
  reg       idleHigh_r;
  reg [2:0] bitCnt_r;
  reg [7:0] shiftIn_r;
  reg [7:0] shiftOut_r;
  reg       haveAddr_r;
  reg       isWrite_r;
  reg       addrOk_r;
  reg [3:0] ptr_r;
  reg       wrEn;
  reg [3:0] wrIdx;
  reg [7:0] wrData;
  wire      captureEdge;
  wire      launchEdge;
  wire [7:0] rxByte;
  wire       byteDone;

  // Mode 1 idles low and mode 3 idles high; both sample on the trailing edge.
  assign captureEdge = wire3S ? sclkRise : (idleHigh_r ? sclkRise : sclkFall);
  assign launchEdge  = wire3S ? sclkFall : (idleHigh_r ? sclkFall : sclkRise);
  assign rxByte      = {shiftIn_r[6:0], sdiS};
  assign byteDone    = selActive & ~accessStart & captureEdge & (bitCnt_r == 3'd7);

  function [7:0] readData;
    input [3:0] idx;
    begin
      if (idx < `NUM_TIME_REGS) begin
        readData = snap_r[idx[2:0]] & readMask(idx);
      end else begin
        readData = regFile_r[idx] & readMask(idx);
      end
    end
  endfunction

  always @* begin
    wrEn   = 1'b0;
    wrIdx  = ptr_r;
    wrData = rxByte & readMask(ptr_r);
    if (byteDone && haveAddr_r && isWrite_r && addrOk_r) begin
      wrEn = 1'b1;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tapPrev_r  <= 1'b0;
      sclkPrev_r <= 1'b0;
      selPrev_r  <= 1'b0;
      idleHigh_r <= 1'b0;
      bitCnt_r   <= 3'd0;
      shiftIn_r  <= 8'h00;
      shiftOut_r <= 8'h00;
      haveAddr_r <= 1'b0;
      isWrite_r  <= 1'b0;
      addrOk_r   <= 1'b0;
      ptr_r      <= `IDX_FIRST;
      sdo        <= 1'b0;
      sdoOe      <= 1'b0;
    end else begin
      tapPrev_r  <= tapS;
      sclkPrev_r <= sclkS;
      selPrev_r  <= selS;
      if (!selActive) begin
        bitCnt_r   <= 3'd0;
        haveAddr_r <= 1'b0;
        sdoOe      <= 1'b0;
        sdo        <= 1'b0;
      end else if (accessStart) begin
        idleHigh_r <= sclkS;
        bitCnt_r   <= 3'd0;
        haveAddr_r <= 1'b0;
      end else begin
        if (captureEdge) begin
          shiftIn_r <= rxByte;
          bitCnt_r  <= bitCnt_r + 3'd1;
        end
        if (byteDone) begin
          if (!haveAddr_r) begin
            haveAddr_r <= 1'b1;
            isWrite_r  <= rxByte[`ADDR_WRITE_BIT];
            addrOk_r   <= ((rxByte & `ADDR_ZERO_MASK) == 8'h00);
            if (!rxByte[`ADDR_WRITE_BIT]) begin
              shiftOut_r <= readData(rxByte[3:0]);
              ptr_r      <= rxByte[3:0] + 4'h1;
            end else begin
              ptr_r <= rxByte[3:0];
            end
          end else begin
            // Wraps from the last location back to the first by overflow.
            ptr_r <= ptr_r + 4'h1;
            if (!isWrite_r) begin
              shiftOut_r <= readData(ptr_r);
            end
          end
        end else if (launchEdge && haveAddr_r && !isWrite_r) begin
          sdo        <= addrOk_r & shiftOut_r[7];
          sdoOe      <= 1'b1;
          shiftOut_r <= {shiftOut_r[6:0], 1'b0};
        end
      end
    end
  end

  // Map storage: a host write overrides the tick in the same cycle.
  integer i;
  integer j;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        regFile_r[i] <= `RST_ZERO;
      end
      regFile_r[`IDX_DOW]   <= `RST_DOW;
      regFile_r[`IDX_DATE]  <= `RST_DATE;
      regFile_r[`IDX_MONTH] <= `RST_MONTH;
    end else begin
      regFile_r[`IDX_HUND]  <= hundNxt;
      regFile_r[`IDX_SEC]   <= secNxt;
      regFile_r[`IDX_MIN]   <= minNxt;
      regFile_r[`IDX_HOUR]  <= hourNxt;
      regFile_r[`IDX_DOW]   <= dowNxt;
      regFile_r[`IDX_DATE]  <= dateNxt;
      regFile_r[`IDX_MONTH] <= monNxt;
      regFile_r[`IDX_YEAR]  <= yearNxt;
      if (wrEn) begin
        regFile_r[wrIdx] <= wrData;
      end
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (j = 0; j < `NUM_TIME_REGS; j = j + 1) begin
        snap_r[j] <= `RST_ZERO;
      end
    end else if (accessStart) begin
      for (j = 0; j < `NUM_TIME_REGS; j = j + 1) begin
        snap_r[j] <= regFile_r[j];
      end
    end
  end

endmodule

// File: hw/rtc_core_defines.vh
`ifndef RTC_CORE_DEFINES_VH
`define RTC_CORE_DEFINES_VH

// Register indices within the 16-location map.
`define IDX_HUND        4'h0
`define IDX_SEC         4'h1
`define IDX_MIN         4'h2
`define IDX_HOUR        4'h3
`define IDX_DOW         4'h4
`define IDX_DATE        4'h5
`define IDX_MONTH       4'h6
`define IDX_YEAR        4'h7
`define IDX_ALM_HUND    4'h8
`define IDX_ALM_SEC     4'h9
`define IDX_ALM_MIN     4'hA
`define IDX_ALM_HOUR    4'hB
`define IDX_ALM_DAYDATE 4'hC
`define IDX_CONTROL     4'hD
`define IDX_STATUS      4'hE
`define IDX_TRICKLE     4'hF
`define IDX_LAST        4'hF
`define IDX_FIRST       4'h0
`define NUM_TIME_REGS   8

// Address byte layout: bit 7 selects write, bits 6..4 must be zero.
`define ADDR_WRITE_BIT  7
`define ADDR_ZERO_MASK  8'h70

// Field positions in the hours and month registers.
`define HOUR_MODE12_BIT 6
`define HOUR_PM_BIT     5
`define MONTH_CENT_BIT  7

// Bits that hold storage; all other bits read as zero.
`define MASK_HUND       8'hFF
`define MASK_SEC        8'h7F
`define MASK_MIN        8'h7F
`define MASK_HOUR       8'h7F
`define MASK_DOW        8'h07
`define MASK_DATE       8'h3F
`define MASK_MONTH      8'h9F
`define MASK_YEAR       8'hFF
`define MASK_FULL       8'hFF
`define MASK_CONTROL    8'hBD
`define MASK_STATUS     8'h81

// Reset values of the time registers.
`define RST_DOW         8'h01
`define RST_DATE        8'h01
`define RST_MONTH       8'h01
`define RST_ZERO        8'h00

// Hundredths generator: 41 for 24 periods, then 40 for one.
`define DIV_LONG        6'd41
`define DIV_SHORT       6'd40
`define DIV_LONG_RUNS   5'd24

`endif

// File: hw/sync_two_flop.v
`timescale 1ns/100ps
// Two-flop synchroniser for a group of unrelated pin levels.
module sync_two_flop #(
  parameter WIDTH = 5
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             resetn,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule

// File: hw/hundredths_divider.v
`timescale 1ns/100ps
`include "rtc_core_defines.vh"
// Turns one pulse per 4096 Hz period into an average 100 Hz tick.
module hundredths_divider (
  // Clock and reset
  input  wire core_clk,
  input  wire resetn,
  // One-cycle pulse per input period, one-cycle tick out
  input  wire inPulse,
  output reg  tickOut
);

  reg [5:0] divCnt_r;
  reg [4:0] runCnt_r;
  wire [5:0] divisor;
  wire       lastCount;

  assign divisor   = (runCnt_r == `DIV_LONG_RUNS) ? `DIV_SHORT : `DIV_LONG;
  assign lastCount = (divCnt_r == divisor - 6'd1);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_r <= 6'd0;
      runCnt_r <= 5'd0;
      tickOut  <= 1'b0;
    end else begin
      tickOut <= inPulse & lastCount;
      if (inPulse) begin
        if (lastCount) begin
          divCnt_r <= 6'd0;
          runCnt_r <= (runCnt_r == `DIV_LONG_RUNS) ? 5'd0 : runCnt_r + 5'd1;
        end else begin
          divCnt_r <= divCnt_r + 6'd1;
        end
      end
    end
  end

endmodule

// File: tb/rtc_core_checker.sv
`timescale 1ns/100ps
module rtc_core_checker (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Pins
  input wire tap4096,
  input wire threeWireMode,
  input wire selPin,
  input wire sclk,
  input wire sdi,
  input wire sdo,
  input wire sdoOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire      selAct;
  wire      launchRaw;
  wire      captureRaw;
  reg       sclkQ_r;
  reg       selActQ_r;
  reg       idleHi_r;
  reg [4:0] capCnt_r;
  reg [2:0] sinceLaunch_r;
  // Raw pin samples; the design's sync latency appears as slack in the ranges below.
  // Edge roles follow the strap and the clock level seen when the select turns active.
  assign selAct     = threeWireMode ? selPin : !selPin;
  assign launchRaw  = (threeWireMode || idleHi_r) ? (sclkQ_r && !sclk) : (!sclkQ_r && sclk);
  assign captureRaw = (threeWireMode || idleHi_r) ? (!sclkQ_r && sclk) : (sclkQ_r && !sclk);
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclkQ_r <= 1'b0;
      selActQ_r <= 1'b0;
      idleHi_r <= 1'b0;
      capCnt_r <= 5'h00;
      sinceLaunch_r <= 3'h7;
    end else begin
      sclkQ_r <= sclk;
      selActQ_r <= selAct;
      if (selAct && !selActQ_r)
        idleHi_r <= sclk;
      if (!selAct)
        capCnt_r <= 5'h00;
      else if (captureRaw && capCnt_r != 5'h1F)
        capCnt_r <= capCnt_r + 5'h01;
      if (launchRaw)
        sinceLaunch_r <= 3'h0;
      else if (sinceLaunch_r != 3'h7)
        sinceLaunch_r <= sinceLaunch_r + 3'h1;
    end
  end
  property p_oe_after_addr; $rose(sdoOe) |-> capCnt_r == 5'h08; endproperty
  property p_oe_in_sel; $rose(sdoOe) |-> selAct && $past(selAct, 4); endproperty
  property p_oe_launch; $rose(sdoOe) |-> sinceLaunch_r inside {[1:6]}; endproperty
  property p_sdo_launch; sdoOe && $past(sdoOe) && $changed(sdo) |-> sinceLaunch_r inside {[1:6]};
  endproperty
  property p_oe_holds; sdoOe && selAct |=> sdoOe; endproperty
  property p_oe_release; $fell(selAct) && sdoOe |-> sdoOe [*2] ##[1:5] !sdoOe; endproperty
  property p_idle; (!selAct) [*6] |-> !sdoOe; endproperty
  property p_sdo_off; !sdoOe |-> !sdo; endproperty
  a_oe_after_addr: assert property (p_oe_after_addr) else $error("drive not after byte one");
  a_oe_in_sel: assert property (p_oe_in_sel) else $error("drive outside select");
  a_oe_launch: assert property (p_oe_launch) else $error("drive not on launch edge");
  a_sdo_launch: assert property (p_sdo_launch) else $error("data moved off launch");
  a_oe_holds: assert property (p_oe_holds) else $error("drive dropped in select");
  a_oe_release: assert property (p_oe_release) else $error("drive release timing");
  a_idle: assert property (p_idle) else $error("drive while idle");
  a_sdo_off: assert property (p_sdo_off) else $error("data high while off");
  c_read: cover property ($rose(sdoOe));
  c_frame: cover property ($rose(selAct));
  c_write: cover property (capCnt_r == 5'h10 && !sdoOe);
  c_three: cover property (threeWireMode && $rose(sdoOe));
endmodule

bind bcd_rtc_timekeeping_core rtc_core_checker rtc_core_checker_inst (
  .core_clk(core_clk), .resetn(resetn), .tap4096(tap4096), .threeWireMode(threeWireMode),
  .selPin(selPin), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe));

// File: tb/spi_host_model.sv
`timescale 1ns/100ps
// Host master: 4-wire with either idle clock level, or 3-wire with an active-high enable.
module spi_host_model (
  // Bus shape chosen by the bench
  input  wire      threeWire,
  input  wire      lead,
  // Pins toward the device
  output reg       selPin,
  output reg       sclk,
  output reg       sdi,
  input  wire      sdo,
  input  wire      sdoOe,
  // Read bytes; rxTick toggles once per byte
  output reg [7:0] rxByte,
  output reg       rxTick
);
  initial begin
    selPin = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    rxByte = 8'h00;
    rxTick = 1'b0;
  end
  // The clock parks opposite its leading edge, so it stands still before select turns active.
  task startFrame();
    sclk = ~lead;
    selPin = ~threeWire;
    #64;
    selPin = threeWire;
    #64;
  endtask
  // Shift on the leading edge, sample on the trailing one; sdi toggles while reading.
  task xferByte(input logic [7:0] tx, input bit rd);
    for (int i = 7; i >= 0; i--) begin
      sclk = lead;
      sdi = rd ? ~sdi : tx[i];
      #32;
      sclk = ~lead;
      // A released line shows the inverse of the last bit, so a silent device cannot pass.
      rxByte = {rxByte[6:0], sdoOe ? sdo : ~rxByte[0]};
      #32;
    end
    if (rd)
      rxTick = ~rxTick;
  endtask
  task endFrame();
    selPin = ~threeWire;
    sdi = ~sdi;
    #128;
  endtask
endmodule

// File: tb/bcd_rtc_timekeeping_core_tb.sv
`timescale 1ns/100ps
module bcd_rtc_timekeeping_core_tb;
  reg          core_clk = 1'b0;
  reg          resetn;
  reg          tap4096;
  reg          threeWireMode;
  reg          sclkLead = 1'b1;
  wire         selPin;
  wire         sclk;
  wire         sdi;
  wire         sdo;
  wire         sdoOe;
  wire [7:0]   rxByte;
  wire         rxTick;
  int          errors = 0;
  int          checked = 0;
  logic [7:0]  expQ[$];
  logic [7:0]  want;
  logic [7:0]  rv[4];
  logic [7:0]  hIn[3] = '{8'h19, 8'h72, 8'h51};
  logic [7:0]  hOut[3] = '{8'h20, 8'h61, 8'h72};
  logic [31:0] seed = 32'h972B1177;

  always #2.5 core_clk = ~core_clk;

  bcd_rtc_timekeeping_core bcd_rtc_timekeeping_core_inst (.core_clk(core_clk), .resetn(resetn),
    .tap4096(tap4096), .threeWireMode(threeWireMode), .selPin(selPin), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe));
  spi_host_model spi_host_model_inst (.threeWire(threeWireMode), .lead(sclkLead),
    .selPin(selPin), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe),
    .rxByte(rxByte), .rxTick(rxTick));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task close_out();
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d[$]);
    spi_host_model_inst.startFrame();
    spi_host_model_inst.xferByte(a | 8'h80, 1'b0);
    foreach (d[i]) spi_host_model_inst.xferByte(d[i], 1'b0);
    spi_host_model_inst.endFrame();
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e[$]);
    spi_host_model_inst.startFrame();
    spi_host_model_inst.xferByte(a, 1'b0);
    foreach (e[i]) begin
      expQ.push_back(e[i]);
      spi_host_model_inst.xferByte(8'h00, 1'b1);
    end
    spi_host_model_inst.endFrame();
  endtask

  task taps(input int n);
    repeat (n) begin
      @(negedge core_clk) tap4096 = 1'b1;
      repeat (8) @(negedge core_clk);
      tap4096 = 1'b0;
      repeat (8) @(negedge core_clk);
    end
    repeat (12) @(negedge core_clk);
  endtask

  always @(rxTick) if (resetn === 1'b1) begin
    want = expQ.size() != 0 ? expQ.pop_front() : 8'hXX;
    checked++;
    if (rxByte !== want) begin
      errors++;
      $display("ERROR %0t read %h expected %h", $time, rxByte, want);
    end
  end

  initial begin
    #300000;
    errors++;
    close_out();
  end

  initial begin
    resetn = 1'b0;
    tap4096 = 1'b0;
    threeWireMode = 1'b0;
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      rv[i] = seed[7:0];
    end
    rd(8'h0E, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
    wr(8'h08, '{rv[0], rv[1], rv[2], rv[3], 8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'h12, 8'h34});
    rd(8'h08, '{rv[0], rv[1], rv[2], rv[3], 8'hFF, 8'hBD, 8'h81, 8'h5A, 8'h12, 8'h34});
    wr(8'h91, '{8'h55});
    rd(8'h11, '{8'h00});
    rd(8'h01, '{8'h34});
    // The divider is idle during each write, so no carry can land between bytes.
    wr(8'h00, '{8'h99, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99});
    taps(40);
    rd(8'h00, '{8'h99});
    fork
      rd(8'h00, '{8'h99, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99});
      begin
        #300;
        taps(1);
      end
    join
    rd(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00});
    wr(8'h00, '{8'h99, 8'h59, 8'h59, 8'h71, 8'h03, 8'h28, 8'h02, 8'h24});
    taps(41);
    rd(8'h00, '{8'h00, 8'h00, 8'h00, 8'h52, 8'h04, 8'h29, 8'h02, 8'h24});
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, '{8'h99, 8'h59, 8'h59, hIn[i]});
      taps(41);
      rd(8'h03, '{hOut[i]});
    end
    // Five ticks have passed; 19 more long periods reach the single short one.
    wr(8'h00, '{8'h00});
    taps(818);
    rd(8'h00, '{8'h19});
    taps(1);
    rd(8'h00, '{8'h20});
    @(negedge core_clk) sclkLead = 1'b0;
    @(negedge core_clk);
    wr(8'h0C, '{rv[2], rv[3]});
    rd(8'h0C, '{rv[2], rv[3] & 8'hBD});
    @(negedge core_clk) threeWireMode = 1'b1;
    @(negedge core_clk);
    wr(8'h0F, '{8'hC3, 8'h45});
    rd(8'h0F, '{8'hC3, 8'h45});
    wait (expQ.size() == 0);
    repeat (10) @(negedge core_clk);
    close_out();
  end
endmodule
